// ===== mtcl_top.sv
// margin trim code limiter: register port, startup load and three trim channels
//
// Contract
// - Each channel holds a read/write 8-bit trim code whose value 0x7F is the midscale point.
// - Each channel holds a read/write 8-bit upper limit that replaces a larger trim code.
// - Each channel holds a read/write 8-bit lower limit that replaces a smaller trim code.
// - A lower limit above the upper limit keeps the output off whatever the enable bit says.
// - The output is on only while bit 2 of the channel control register is set.
// - Control bits [1:0] select midscale 1.25 V, 1.0 V, 0.8 V or 0.6 V for codes 00 to 11.
// - Limits and other registers are loaded from nonvolatile storage before software writes are accepted.
`timescale 1ns/10ps
module mtcl_top
    import mtcl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // startup load from nonvolatile storage
    input wire logic nv_wr,
    input wire logic [7:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    input wire logic nv_done,
    // software register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic load_done,
    // converter drive, index 0 is channel 2
    output mtcl_chan_s [NCH-1:0] trim_out
);

    mtcl_load_e load_q;
    mtcl_load_e load_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic wr_any;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    mtcl_wr_s [NCH-1:0] ch_wr;
    mtcl_regs_s [NCH-1:0] ch_regs;
    mtcl_chan_s [NCH-1:0] ch_out;

    // load sequencing: software writes are held off until storage is copied in
    always_comb begin
        load_d = load_q;
        unique case (load_q)
            LD_WAIT: begin
                if (nv_done) begin
                    load_d = LD_RUN;
                end
            end
            LD_RUN: begin
                load_d = LD_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_q <= LD_WAIT;
        end else begin
            load_q <= load_d;
        end
    end

    // one write source at a time; the other side is ignored, not queued
    always_comb begin
        if (load_q == LD_RUN) begin
            wr_any = reg_wr;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
        end else begin
            wr_any = nv_wr;
            wr_addr = nv_addr;
            wr_data = nv_wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_wr[i].ctrl = wr_any && (wr_addr == CTRL_ADDR[i]);
            ch_wr[i].code = wr_any && (wr_addr == CODE_ADDR[i]);
            ch_wr[i].upper = wr_any && (wr_addr == UPPER_ADDR[i]);
            ch_wr[i].lower = wr_any && (wr_addr == LOWER_ADDR[i]);
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        mtcl_channel u_ch (
            .clk(clk),
            .rst_n(rst_n),
            .wr(ch_wr[g]),
            .wdata(wr_data),
            .regs_q(ch_regs[g]),
            .out_q(ch_out[g])
        );
    end

    // read path: one cycle latency, unmapped addresses read zero
    always_comb begin
        rdata_d = RDATA_NONE;
        rvalid_d = reg_rd;
        if (reg_rd) begin
            for (int i = 0; i < NCH; i++) begin
                if (reg_addr == CTRL_ADDR[i]) begin
                    rdata_d = ch_regs[i].ctrl & CTRL_USED_MASK;
                end
                if (reg_addr == CODE_ADDR[i]) begin
                    rdata_d = ch_regs[i].code;
                end
                if (reg_addr == UPPER_ADDR[i]) begin
                    rdata_d = ch_regs[i].upper;
                end
                if (reg_addr == LOWER_ADDR[i]) begin
                    rdata_d = ch_regs[i].lower;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= RDATA_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign load_done = load_q == LD_RUN;
    assign trim_out = ch_out;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_ctrl_read_upper_zero;
        reg_rd && (reg_addr == TRIM_CTRL_CH2_ADDR || reg_addr == TRIM_CTRL_CH3_ADDR
            || reg_addr == TRIM_CTRL_CH4_ADDR) |=> reg_rdata[7:3] == 5'b00000;
    endproperty
    a_ctrl_read_upper_zero: assert property (p_ctrl_read_upper_zero)
        else $error("control read shows unusable bits set");

    property p_sw_write_blocked;
        load_q == LD_WAIT && reg_wr && !nv_wr |=> $stable(ch_regs);
    endproperty
    a_sw_write_blocked: assert property (p_sw_write_blocked)
        else $error("software write landed before startup load finished");

    property p_nv_ignored_after_load;
        load_done && nv_wr && !reg_wr |=> $stable(ch_regs);
    endproperty
    a_nv_ignored_after_load: assert property (p_nv_ignored_after_load)
        else $error("startup write landed after load finished");

    property p_load_enters;
        !load_done && nv_done |=> load_done;
    endproperty
    a_load_enters: assert property (p_load_enters)
        else $error("load phase did not end on done");

    property p_load_sticky;
        load_done |=> load_done;
    endproperty
    a_load_sticky: assert property (p_load_sticky)
        else $error("load done dropped");

    property p_rvalid_one_cycle;
        1'b1 |=> reg_rvalid == $past(reg_rd);
    endproperty
    a_rvalid_one_cycle: assert property (p_rvalid_one_cycle)
        else $error("read valid does not trail the read strobe by one cycle");

    // data lines rest at zero between reads
    property p_idle_rdata_zero;
        !reg_rvalid |-> reg_rdata == RDATA_NONE;
    endproperty
    a_idle_rdata_zero: assert property (p_idle_rdata_zero)
        else $error("read data not zero outside a read");

    property p_unmapped_read_zero;
        reg_rd && reg_addr < TRIM_CTRL_CH2_ADDR |=> reg_rdata == RDATA_NONE;
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("unmapped address read nonzero");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_code_stored;
            load_done && reg_wr && reg_addr == CODE_ADDR[g]
                |=> ch_regs[g].code == $past(reg_wdata);
        endproperty
        a_code_stored: assert property (p_code_stored)
            else $error("trim code write not stored");

        property p_upper_stored;
            load_done && reg_wr && reg_addr == UPPER_ADDR[g]
                |=> ch_regs[g].upper == $past(reg_wdata);
        endproperty
        a_upper_stored: assert property (p_upper_stored)
            else $error("upper limit write not stored");

        property p_lower_stored;
            load_done && reg_wr && reg_addr == LOWER_ADDR[g]
                |=> ch_regs[g].lower == $past(reg_wdata);
        endproperty
        a_lower_stored: assert property (p_lower_stored)
            else $error("lower limit write not stored");

        property p_ctrl_stored;
            load_done && reg_wr && reg_addr == CTRL_ADDR[g]
                |=> ch_regs[g].ctrl == ($past(reg_wdata) & CTRL_USED_MASK);
        endproperty
        a_ctrl_stored: assert property (p_ctrl_stored)
            else $error("control write not stored with unusable bits cleared");

        // storage copies the limits in before software writes can reach them
        property p_nv_upper_stored;
            !load_done && nv_wr && nv_addr == UPPER_ADDR[g]
                |=> ch_regs[g].upper == $past(nv_wdata);
        endproperty
        a_nv_upper_stored: assert property (p_nv_upper_stored)
            else $error("startup upper limit not stored");

        property p_nv_lower_stored;
            !load_done && nv_wr && nv_addr == LOWER_ADDR[g]
                |=> ch_regs[g].lower == $past(nv_wdata);
        endproperty
        a_nv_lower_stored: assert property (p_nv_lower_stored)
            else $error("startup lower limit not stored");

        property p_code_read;
            reg_rd && reg_addr == CODE_ADDR[g] |=> reg_rdata == $past(ch_regs[g].code);
        endproperty
        a_code_read: assert property (p_code_read)
            else $error("trim code read differs from register");

        property p_pass_in_range;
            ch_regs[g].code <= ch_regs[g].upper && ch_regs[g].code >= ch_regs[g].lower
                |=> trim_out[g].code == $past(ch_regs[g].code);
        endproperty
        a_pass_in_range: assert property (p_pass_in_range)
            else $error("in-range code not passed to converter");

        property p_clamp_upper;
            // the edge that releases reset still shows the reset drive, not the clamp
            rst_n && ch_regs[g].code > ch_regs[g].upper
                |=> trim_out[g].code == $past(ch_regs[g].upper);
        endproperty
        a_clamp_upper: assert property (p_clamp_upper)
            else $error("code above upper limit not clamped");

        property p_clamp_lower;
            ch_regs[g].code < ch_regs[g].lower && ch_regs[g].lower <= ch_regs[g].upper
                |=> trim_out[g].code == $past(ch_regs[g].lower);
        endproperty
        a_clamp_lower: assert property (p_clamp_lower)
            else $error("code below lower limit not clamped");

        property p_inverted_off;
            ch_regs[g].lower > ch_regs[g].upper |=> !trim_out[g].drive_en;
        endproperty
        a_inverted_off: assert property (p_inverted_off)
            else $error("output on with inverted limits");

        property p_enable_follows;
            ch_regs[g].lower <= ch_regs[g].upper
                |=> trim_out[g].drive_en == $past(ch_regs[g].ctrl[CTRL_ENABLE_BIT]);
        endproperty
        a_enable_follows: assert property (p_enable_follows)
            else $error("output enable does not follow control bit");

        property p_disabled_off;
            !ch_regs[g].ctrl[CTRL_ENABLE_BIT] |=> !trim_out[g].drive_en;
        endproperty
        a_disabled_off: assert property (p_disabled_off)
            else $error("output on with enable bit clear");

        property p_within_limits;
            ch_regs[g].lower <= ch_regs[g].upper
                |=> trim_out[g].code <= $past(ch_regs[g].upper)
                && trim_out[g].code >= $past(ch_regs[g].lower);
        endproperty
        a_within_limits: assert property (p_within_limits)
            else $error("converter code outside the limit window");

        property p_midscale_sel;
            ##1 1'b1 |-> trim_out[g].midscale_offset_select == $past(ch_regs[g].ctrl[1:0]);
        endproperty
        a_midscale_sel: assert property (p_midscale_sel)
            else $error("midscale select differs from control field");
    end

    c_load_then_write: cover property (load_q == LD_WAIT ##1 load_done ##[1:20] reg_wr);
    c_clamp_high: cover property (trim_out[1].drive_en && ch_regs[1].code > ch_regs[1].upper);
    c_clamp_low: cover property (trim_out[0].drive_en && ch_regs[0].code < ch_regs[0].lower);
    c_inverted_enabled: cover property (ch_regs[1].ctrl[CTRL_ENABLE_BIT]
        && ch_regs[1].lower > ch_regs[1].upper);

endmodule

// ===== mtcl_pkg.sv
// constants, types and register map of the margin trim code limiter
package mtcl_pkg;

    localparam int NCH = 3;

    // register map, channel 2 first
    localparam logic [7:0] TRIM_CTRL_CH2_ADDR = 8'h51;
    localparam logic [7:0] TRIM_CTRL_CH3_ADDR = 8'h52;
    localparam logic [7:0] TRIM_CTRL_CH4_ADDR = 8'h53;
    localparam logic [7:0] TRIM_CODE_CH2_ADDR = 8'h59;
    localparam logic [7:0] TRIM_CODE_CH3_ADDR = 8'h5A;
    localparam logic [7:0] TRIM_CODE_CH4_ADDR = 8'h5B;
    localparam logic [7:0] TRIM_UPPER_LIMIT_CH2_ADDR = 8'h61;
    localparam logic [7:0] TRIM_UPPER_LIMIT_CH3_ADDR = 8'h62;
    localparam logic [7:0] TRIM_UPPER_LIMIT_CH4_ADDR = 8'h63;
    localparam logic [7:0] TRIM_LOWER_LIMIT_CH2_ADDR = 8'h69;
    localparam logic [7:0] TRIM_LOWER_LIMIT_CH3_ADDR = 8'h6A;
    localparam logic [7:0] TRIM_LOWER_LIMIT_CH4_ADDR = 8'h6B;

    localparam logic [7:0] CTRL_ADDR [NCH] = '{TRIM_CTRL_CH2_ADDR, TRIM_CTRL_CH3_ADDR,
        TRIM_CTRL_CH4_ADDR};
    localparam logic [7:0] CODE_ADDR [NCH] = '{TRIM_CODE_CH2_ADDR, TRIM_CODE_CH3_ADDR,
        TRIM_CODE_CH4_ADDR};
    localparam logic [7:0] UPPER_ADDR [NCH] = '{TRIM_UPPER_LIMIT_CH2_ADDR,
        TRIM_UPPER_LIMIT_CH3_ADDR, TRIM_UPPER_LIMIT_CH4_ADDR};
    localparam logic [7:0] LOWER_ADDR [NCH] = '{TRIM_LOWER_LIMIT_CH2_ADDR,
        TRIM_LOWER_LIMIT_CH3_ADDR, TRIM_LOWER_LIMIT_CH4_ADDR};

    // control register fields
    localparam int CTRL_ENABLE_BIT = 2;
    localparam logic [7:0] CTRL_USED_MASK = 8'h07;

    // reset values: limits start inverted so the output stays off until loaded
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CODE = 8'h7F;
    localparam logic [7:0] RST_UPPER = 8'h00;
    localparam logic [7:0] RST_LOWER = 8'hFF;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    typedef enum logic [1:0] {
        MID_1V25 = 2'b00,
        MID_1V00 = 2'b01,
        MID_0V80 = 2'b10,
        MID_0V60 = 2'b11
    } mtcl_offset_e;

    typedef enum logic {
        LD_WAIT = 1'b0,
        LD_RUN = 1'b1
    } mtcl_load_e;

    typedef struct packed {
        logic ctrl;
        logic code;
        logic upper;
        logic lower;
    } mtcl_wr_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] code;
        logic [7:0] upper;
        logic [7:0] lower;
    } mtcl_regs_s;

    typedef struct packed {
        logic drive_en;
        mtcl_offset_e midscale_offset_select;
        logic [7:0] code;
    } mtcl_chan_s;

endpackage

// ===== mtcl_channel.sv
// one trim channel: its four registers and the clamped converter drive
`timescale 1ns/10ps
module mtcl_channel
    import mtcl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register writes
    input wire mtcl_wr_s wr,
    input wire logic [7:0] wdata,
    // state
    output mtcl_regs_s regs_q,
    output mtcl_chan_s out_q
);

    mtcl_regs_s regs_d;
    mtcl_chan_s out_d;
    logic inverted;

    always_comb begin
        regs_d = regs_q;
        if (wr.ctrl) begin
            regs_d.ctrl = wdata & CTRL_USED_MASK;
        end
        if (wr.code) begin
            regs_d.code = wdata;
        end
        if (wr.upper) begin
            regs_d.upper = wdata;
        end
        if (wr.lower) begin
            regs_d.lower = wdata;
        end
    end

    always_comb begin
        inverted = regs_q.lower > regs_q.upper;
        out_d.midscale_offset_select = mtcl_offset_e'(regs_q.ctrl[1:0]);
        // inverted limits override the enable bit
        out_d.drive_en = regs_q.ctrl[CTRL_ENABLE_BIT] && !inverted;
        if (regs_q.code > regs_q.upper) begin
            out_d.code = regs_q.upper;
        end else if (regs_q.code < regs_q.lower) begin
            out_d.code = regs_q.lower;
        end else begin
            out_d.code = regs_q.code;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= '{ctrl: RST_CTRL, code: RST_CODE, upper: RST_UPPER, lower: RST_LOWER};
            out_q <= '{drive_en: 1'b0, midscale_offset_select: MID_1V25, code: RST_CODE};
        end else begin
            regs_q <= regs_d;
            out_q <= out_d;
        end
    end

endmodule

// ===== mtcl_conv_model.sv
// behavioural trim feedback node of the dc-to-dc converter on each channel
`timescale 1ns/10ps
module mtcl_conv_model
    import mtcl_pkg::*;
(
    // converter drive from the limiter
    input wire mtcl_chan_s [NCH-1:0] trim_out,
    // what each trim node sees
    output logic [NCH-1:0] node_driven,
    output logic [7:0] node_code [NCH]
);
    // a released node has no pull, so it shows the inverse rather than a stale code
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            node_driven[i] = trim_out[i].drive_en;
            node_code[i] = trim_out[i].drive_en ? trim_out[i].code : ~trim_out[i].code;
        end
    end
endmodule

// ===== tb.sv
// self-checking bench for the margin trim code limiter
`timescale 1ns/10ps
module tb;
    import mtcl_pkg::*;
    logic clk, rst_n, nv_wr, nv_done, reg_wr, reg_rd, reg_rvalid, load_done;
    logic [7:0] nv_addr, nv_wdata, reg_addr, reg_wdata, reg_rdata;
    mtcl_chan_s [NCH-1:0] trim_out;
    logic [NCH-1:0] node_driven;
    logic [7:0] node_code [NCH];
    int num_errors = 0;
    int n_checks = 0;

    mtcl_top mtcl_top_i (.clk(clk), .rst_n(rst_n), .nv_wr(nv_wr), .nv_addr(nv_addr),
        .nv_wdata(nv_wdata), .nv_done(nv_done), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .load_done(load_done), .trim_out(trim_out));
    mtcl_conv_model mtcl_conv_model_i (.trim_out(trim_out), .node_driven(node_driven),
        .node_code(node_code));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk_bit(reg_rvalid, 1'b1);
        chk_byte(reg_rdata, exp);
    endtask

    task automatic nv_load(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        nv_wr <= 1'b1;
        nv_addr <= a;
        nv_wdata <= d;
        @(posedge clk);
        nv_wr <= 1'b0;
    endtask

    // register change lands one edge after the write, the drive one edge later
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_startup;
        wr(CODE_ADDR[1], 8'h11);
        rd(CODE_ADDR[1], RST_CODE);
        rd(LOWER_ADDR[1], RST_LOWER);
        chk_bit(node_driven[1], 1'b0);
        for (int ch = 0; ch < NCH; ch++) begin
            nv_load(UPPER_ADDR[ch], 8'hC0);
            nv_load(LOWER_ADDR[ch], 8'h40);
        end
        @(posedge clk);
        nv_done <= 1'b1;
        for (int i = 0; i < 8 && load_done !== 1'b1; i++) @(posedge clk);
        #1;
        chk_bit(load_done, 1'b1);
        nv_load(UPPER_ADDR[0], 8'h55);
        rd(UPPER_ADDR[0], 8'hC0);
        rd(LOWER_ADDR[2], 8'h40);
    endtask

    task automatic t_clamp;
        logic [7:0] codes [7] = '{8'h20, 8'h3F, 8'h40, 8'h7F, 8'hC0, 8'hC1, 8'hE0};
        logic [7:0] exp;
        for (int ch = 0; ch < NCH; ch++) begin
            wr(CTRL_ADDR[ch], 8'h04);
            foreach (codes[k]) begin
                exp = codes[k] > 8'hC0 ? 8'hC0 : (codes[k] < 8'h40 ? 8'h40 : codes[k]);
                wr(CODE_ADDR[ch], codes[k]);
                settle();
                chk_bit(node_driven[ch], 1'b1);
                chk_byte(node_code[ch], exp);
                rd(CODE_ADDR[ch], codes[k]);
            end
        end
    endtask

    task automatic t_inverted;
        wr(LOWER_ADDR[1], 8'hC1);
        settle();
        chk_bit(node_driven[1], 1'b0);
        wr(LOWER_ADDR[1], 8'hC0);
        settle();
        chk_bit(node_driven[1], 1'b1);
        chk_byte(node_code[1], 8'hC0);
        wr(UPPER_ADDR[1], 8'hD0);
        rd(UPPER_ADDR[1], 8'hD0);
        settle();
        chk_byte(node_code[1], 8'hD0);
    endtask

    task automatic t_offset;
        for (int s = 0; s < 4; s++) begin
            wr(CTRL_ADDR[2], 8'hFC | 8'(s));
            rd(CTRL_ADDR[2], 8'h04 | 8'(s));
            settle();
            chk_byte({6'h0, trim_out[2].midscale_offset_select}, 8'(s));
        end
        wr(CTRL_ADDR[2], 8'h03);
        settle();
        chk_bit(node_driven[2], 1'b0);
        wr(8'h50, 8'hAA);
        rd(8'h50, RDATA_NONE);
    endtask

    initial begin
        rst_n = 1'b0;
        {nv_wr, nv_done, reg_wr, reg_rd} = 4'h0;
        {nv_addr, nv_wdata, reg_addr, reg_wdata} = 32'h0000_0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_startup();
        t_clamp();
        t_inverted();
        t_offset();
        complete_run();
    end

    // the tests need about 220 cycles; this allows ample margin
    initial begin
        #200000;
        num_errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run();
    end
endmodule
